// ### rtl/sdram_pins_defs.svh
/*
 * constants for the sdram pin interface: widths, clock rates, commands.
 * assumes inclusion from the package, the pin interface module, the dimm model and the bench.
 */
// What this block does
// (R01) data moves over a 64-bit bidirectional bus
// (R02) row and column share thirteen address lines
// (R03) 16 Mbit mode: addr 11, bank 1 select
// (R04) chip selects gate all inputs except clocks
// (R05) row/column strobes low, each output twice
// (R06) write enable high on read, low write
// (R07) eight byte masks block data per lane
// (R08) memory clock from pll, 66 MHz default; here a divider of the 100 MHz system clock gives 25 MHz
// (R09) controller runs on returned buffered memory clock
// (R10) command outputs change on returned clock edge
`ifndef SDRAM_PINS_DEFS_SVH
`define SDRAM_PINS_DEFS_SVH
`define DATA_W        64
`define ADDR_W        13
`define MASK_W        8
`define CS_W          2
`define ADDR_CS2_BIT  11
`define SYS_CLK_MHZ   100
`define MEM_CLK_MHZ   66
`define MEM_CLK_DIV   ((`SYS_CLK_MHZ + `MEM_CLK_MHZ - 1) / `MEM_CLK_MHZ)
`define CMD_NOP       4'h7
`define CMD_ACTIVE    4'h3
`define CMD_READ      4'h5
`define CMD_WRITE     4'h4
`endif

// ### rtl/sdram_pins_pkg.sv
/*
 * types for the sdram pin interface.
 * assumes the constants header sits beside it in rtl/.
 */
`include "sdram_pins_defs.svh"
package sdram_pins_pkg;
   // one request from the controller core
   typedef struct packed {
      logic                 write;
      logic [1:0]           bank;
      logic [`ADDR_W-1:0]   row;
      logic [`ADDR_W-1:0]   col;
      logic [3:0]           cs_sel;
      logic [`MASK_W-1:0]   mask;
      logic [`DATA_W-1:0]   wdata;
   } mem_req_t;
   // command pins, before duplication
   typedef struct packed {
      logic                 ras_n;
      logic                 cas_n;
      logic                 we_n;
   } mem_cmd_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACT  = 2'b01,
      ST_RW   = 2'b10,
      ST_DATA = 2'b11
   } seq_st_t;
endpackage

// ### rtl/sdram_pin_interface.sv
/*
 * sdram pin sequencer: takes a request, issues activate then read or write
 * on the pins, moving every command on a rising edge of the returned memory
 * clock. assumes the board loops the memory clock back matched to the dimms.
 */
`timescale 1ns/1ns
`include "sdram_pins_defs.svh"
module sdram_pin_interface (
   // clock and reset
   input  wire logic                     clk_sys_in,
   input  wire logic                     rst_in,
   // configuration
   input  wire logic                     small_parts_in,
   // request side
   input  wire logic                     req_valid_in,
   input  sdram_pins_pkg::mem_req_t      req_in,
   output logic                          req_ready_out,
   output logic                          rd_valid_out,
   output logic [`DATA_W-1:0]            rd_data_out,
   // memory clock
   output logic                          mem_clk_out,
   input  wire logic                     mem_clk_return_in,
   // memory pins
   output logic [`ADDR_W-1:0]            row_col_addr_out,
   output logic [1:0]                    bank_addr_out,
   output logic [`CS_W-1:0]              chip_select_n_out,
   output logic [1:0]                    row_strobe_n_out,
   output logic [1:0]                    col_strobe_n_out,
   output logic                          mem_write_enable_n_out,
   output logic [`MASK_W-1:0]            data_mask_n_out,
   input  wire logic [`DATA_W-1:0]       mem_data_in,
   output logic [`DATA_W-1:0]            mem_data_out,
   output logic                          mem_data_oe_out
);
   import sdram_pins_pkg::*;

   // clock divider stands in for the pll; rounds rate down, never above 66
   logic [3:0] div_r, div_nxt;
   logic       mclk_r, mclk_nxt;
   always_comb begin
      div_nxt  = div_r + 4'h1;
      mclk_nxt = mclk_r;
      if (div_r == 4'(`MEM_CLK_DIV - 1)) begin
         div_nxt  = 4'h0;
         mclk_nxt = ~mclk_r; // (R08)
      end
   end
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         div_r  <= 4'h0;
         mclk_r <= 1'b0;
      end else begin
         div_r  <= div_nxt;
         mclk_r <= mclk_nxt;
      end
   end
   assign mem_clk_out = mclk_r;

   // returned clock is sampled twice, then its rising edge is the step enable
   logic [2:0] rsync_r, rsync_nxt;
   logic       step;
   always_comb rsync_nxt = {rsync_r[1:0], mem_clk_return_in};
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) rsync_r <= 3'h0;
      else        rsync_r <= rsync_nxt;
   end
   assign step = rsync_r[1] & ~rsync_r[2]; // (R09)

   // mode pin and memory data come from outside this clock, two flops each;
   // read data stands a whole memory clock, so the delay still lands inside it
   logic [1:0]            small_sync_r, small_sync_nxt;
   logic [`DATA_W-1:0]    mdat_s1_r, mdat_s1_nxt;
   logic [`DATA_W-1:0]    mdat_s2_r, mdat_s2_nxt;
   always_comb begin
      small_sync_nxt = {small_sync_r[0], small_parts_in};
      mdat_s1_nxt    = mem_data_in;
      mdat_s2_nxt    = mdat_s1_r;
   end
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         small_sync_r <= 2'h0;
         mdat_s1_r    <= '0;
         mdat_s2_r    <= '0;
      end else begin
         small_sync_r <= small_sync_nxt;
         mdat_s1_r    <= mdat_s1_nxt;
         mdat_s2_r    <= mdat_s2_nxt;
      end
   end

   // sequencer state and pin registers
   seq_st_t               st_r, st_nxt;
   mem_req_t              req_r, req_nxt;
   mem_cmd_t              cmd_r, cmd_nxt;
   logic [`ADDR_W-1:0]    addr_r, addr_nxt;
   logic [1:0]            ba_r, ba_nxt;
   logic [`CS_W-1:0]      cs_r, cs_nxt;
   logic [`MASK_W-1:0]    dqm_r, dqm_nxt;
   logic                  oe_r, oe_nxt;
   logic                  rdv_r, rdv_nxt;
   logic [`DATA_W-1:0]    rdd_r, rdd_nxt;

   // idle pins: both chip select pins high, extra selects on addr 11 and bank 1 held, strobes high, masks active
   function automatic mem_cmd_t to_cmd(input logic [3:0] c);
      to_cmd = '{ras_n: c[2], cas_n: c[1], we_n: c[0]};
   endfunction

   assign req_ready_out = (st_r == ST_IDLE) && step;

   always_comb begin
      st_nxt   = st_r;
      req_nxt  = req_r;
      cmd_nxt  = cmd_r;
      addr_nxt = addr_r;
      ba_nxt   = ba_r;
      cs_nxt   = cs_r;
      dqm_nxt  = dqm_r;
      oe_nxt   = oe_r;
      rdv_nxt  = 1'b0;
      rdd_nxt  = rdd_r;
      if (step) begin // (R10)
         cmd_nxt = to_cmd(`CMD_NOP);
         cs_nxt  = {`CS_W{1'b1}};
         oe_nxt  = 1'b0;
         dqm_nxt = {`MASK_W{1'b1}};
         case (st_r)
            ST_IDLE: begin
               if (req_valid_in) begin
                  req_nxt = req_in;
                  st_nxt  = ST_ACT;
               end
            end
            ST_ACT: begin
               cmd_nxt  = to_cmd(`CMD_ACTIVE);
               cs_nxt   = ~req_r.cs_sel[1:0]; // (R04)
               addr_nxt = req_r.row;         // (R02)
               ba_nxt   = req_r.bank;
               if (small_sync_r[1]) begin    // (R03)
                  addr_nxt[`ADDR_CS2_BIT] = ~req_r.cs_sel[2];
                  ba_nxt[1]               = ~req_r.cs_sel[3];
               end
               st_nxt = ST_RW;
            end
            ST_RW: begin
               cmd_nxt  = to_cmd(req_r.write ? `CMD_WRITE : `CMD_READ); // (R06)
               cs_nxt   = ~req_r.cs_sel[1:0];
               addr_nxt = req_r.col;         // (R02)
               if (small_sync_r[1]) begin    // (R03)
                  addr_nxt[`ADDR_CS2_BIT] = ~req_r.cs_sel[2];
                  ba_nxt[1]               = ~req_r.cs_sel[3];
               end
               dqm_nxt = ~req_r.mask;        // (R07)
               oe_nxt  = req_r.write;        // (R01)
               st_nxt  = ST_DATA;
            end
            ST_DATA: begin
               // read data sampled one memory clock after the read command
               if (!req_r.write) begin
                  rdv_nxt = 1'b1;
                  rdd_nxt = mdat_s2_r;       // (R01)
               end
               st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         st_r   <= ST_IDLE;
         req_r  <= '0;
         cmd_r  <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
         addr_r <= '0;
         ba_r   <= 2'h0;
         cs_r   <= {`CS_W{1'b1}};
         dqm_r  <= {`MASK_W{1'b1}};
         oe_r   <= 1'b0;
         rdv_r  <= 1'b0;
         rdd_r  <= '0;
      end else begin
         st_r   <= st_nxt;
         req_r  <= req_nxt;
         cmd_r  <= cmd_nxt;
         addr_r <= addr_nxt;
         ba_r   <= ba_nxt;
         cs_r   <= cs_nxt;
         dqm_r  <= dqm_nxt;
         oe_r   <= oe_nxt;
         rdv_r  <= rdv_nxt;
         rdd_r  <= rdd_nxt;
      end
   end

   // one internal strobe fans out to two identical pins
   assign row_strobe_n_out       = {2{cmd_r.ras_n}}; // (R05)
   assign col_strobe_n_out       = {2{cmd_r.cas_n}}; // (R05)
   assign mem_write_enable_n_out = cmd_r.we_n;
   assign row_col_addr_out       = addr_r;
   assign bank_addr_out          = ba_r;
   assign chip_select_n_out      = cs_r;
   assign data_mask_n_out        = dqm_r;
   assign mem_data_out           = req_r.wdata;
   assign mem_data_oe_out        = oe_r;
   assign rd_valid_out           = rdv_r;
   assign rd_data_out            = rdd_r;

   // checks
   strobe_copies_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      row_strobe_n_out[0] == row_strobe_n_out[1] && col_strobe_n_out[0] == col_strobe_n_out[1])
      else $error("strobe copies differ"); // (R05)
   pins_on_step_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !step |=> $stable(row_strobe_n_out) && $stable(chip_select_n_out))
      else $error("command pins moved off the return edge"); // (R10)
   write_we_low_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (step && st_r == ST_RW && req_r.write) |=> !mem_write_enable_n_out && mem_data_oe_out)
      else $error("write without low write enable"); // (R06)
   read_we_high_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (step && st_r == ST_RW && !req_r.write) |=> mem_write_enable_n_out && !mem_data_oe_out)
      else $error("read with low write enable"); // (R06)
   row_addr_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (step && st_r == ST_ACT && !small_parts_in) |=> row_col_addr_out == $past(req_r.row))
      else $error("row address not driven at activate"); // (R02)
   extra_cs_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (step && st_r == ST_ACT && small_parts_in)
      |=> row_col_addr_out[`ADDR_CS2_BIT] == !$past(req_r.cs_sel[2]) && bank_addr_out[1] == !$past(req_r.cs_sel[3]))
      else $error("extra chip selects wrong"); // (R03)
   mask_lane_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (step && st_r == ST_RW) |=> data_mask_n_out == ~$past(req_r.mask))
      else $error("byte masks wrong"); // (R07)
   idle_cs_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (step && st_r == ST_IDLE) |=> chip_select_n_out == 2'h3)
      else $error("chip select active while idle"); // (R04)
   clk_toggle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (div_r == 4'h1) |=> mem_clk_out != $past(mem_clk_out))
      else $error("memory clock not toggling"); // (R08)
   read_cap_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (step && st_r == ST_DATA && !req_r.write) |=> rd_valid_out && rd_data_out == $past(mem_data_in, 3))
      else $error("read data not captured"); // (R01)
endmodule // sdram_pin_interface

// ### test/dimm_model.sv
/*
 * behavioural dimm answering on chip select 0, one memory clock read latency.
 * assumes the returned memory clock samples the command pins.
 */
`timescale 1ns/1ns
`include "sdram_pins_defs.svh"
module dimm_model (
   // clock
   input  wire logic                mclk_in,
   // command and address pins
   input  wire logic [`ADDR_W-1:0]  addr_in,
   input  wire logic [1:0]          bank_in,
   input  wire logic [`CS_W-1:0]    cs_n_in,
   input  wire logic [1:0]          ras_n_in,
   input  wire logic [1:0]          cas_n_in,
   input  wire logic                we_n_in,
   input  wire logic [`MASK_W-1:0]  mask_n_in,
   // data pins
   input  wire logic [`DATA_W-1:0]  dq_in,
   input  wire logic                dq_oe_in,
   output logic [`DATA_W-1:0]       dq_out
);
   logic [`DATA_W-1:0] mem [32];
   logic [4:0]         idx;
   logic               col_cmd;
   initial begin
      foreach (mem[i]) mem[i] = '0;
      dq_out = '0;
   end
   // released lanes flip every clock so a stale value never passes
   always @(posedge mclk_in) begin
      idx = {bank_in[0], addr_in[3:0]};
      col_cmd = !cs_n_in[0] && ras_n_in == 2'b11 && cas_n_in == 2'b00;
      for (int l = 0; l < `MASK_W; l++) begin
         if (col_cmd && !we_n_in && dq_oe_in && !mask_n_in[l])
            mem[idx][8*l +: 8] = dq_in[8*l +: 8];
         if (col_cmd && we_n_in && !mask_n_in[l])
            dq_out[8*l +: 8] <= mem[idx][8*l +: 8];
         else
            dq_out[8*l +: 8] <= ~dq_out[8*l +: 8];
      end
   end
endmodule // dimm_model

// ### test/tb.sv
/*
 * bench for the sdram pin sequencer: random write/read pairs against a dimm.
 * assumes the dimm model on chip select 0 and a free running return clock.
 */
`timescale 1ns/1ns
`include "sdram_pins_defs.svh"
module tb;
   import sdram_pins_pkg::*;
   logic               clk_sys_in, rst_in, small_parts_in, req_valid_in, mem_clk_return_in;
   mem_req_t           req_in, r;
   logic               req_ready_out, rd_valid_out, mem_clk_out, mem_write_enable_n_out, mem_data_oe_out, prev;
   logic [`DATA_W-1:0] rd_data_out, mem_data_in, mem_data_out;
   logic [`ADDR_W-1:0] row_col_addr_out;
   logic [1:0]         bank_addr_out, row_strobe_n_out, col_strobe_n_out;
   logic [`CS_W-1:0]   chip_select_n_out;
   logic [`MASK_W-1:0] data_mask_n_out;
   logic [63:0]        shadow [32];
   int                 fails, n_compared, k;

   sdram_pin_interface dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .small_parts_in(small_parts_in),
      .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
      .rd_data_out(rd_data_out), .mem_clk_out(mem_clk_out), .mem_clk_return_in(mem_clk_return_in),
      .row_col_addr_out(row_col_addr_out), .bank_addr_out(bank_addr_out), .chip_select_n_out(chip_select_n_out),
      .row_strobe_n_out(row_strobe_n_out), .col_strobe_n_out(col_strobe_n_out),
      .mem_write_enable_n_out(mem_write_enable_n_out), .data_mask_n_out(data_mask_n_out),
      .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out));
   dimm_model dimm_u (.mclk_in(mem_clk_return_in), .addr_in(row_col_addr_out), .bank_in(bank_addr_out),
      .cs_n_in(chip_select_n_out), .ras_n_in(row_strobe_n_out), .cas_n_in(col_strobe_n_out),
      .we_n_in(mem_write_enable_n_out), .mask_n_in(data_mask_n_out), .dq_in(mem_data_out),
      .dq_oe_in(mem_data_oe_out), .dq_out(mem_data_in));

   // clocks: the return clock is unrelated in phase to the system clock
   initial begin clk_sys_in = 0; forever #5 clk_sys_in = ~clk_sys_in; end
   initial begin mem_clk_return_in = 0; #3; forever #40 mem_clk_return_in = ~mem_clk_return_in; end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // byte lane enables widened to the data bus
   function automatic logic [63:0] lanes(input logic [7:0] m);
      for (int i = 0; i < 8; i++) lanes[8*i +: 8] = {8{m[i]}};
   endfunction
   // address pins as expected with the extra select on bit 11 folded in
   function automatic logic [12:0] ex_addr(input logic [12:0] a, input logic [3:0] c);
      ex_addr = a;
      if (small_parts_in) ex_addr[11] = ~c[2];
   endfunction
   // one whole transfer, pins checked at activate and at the read or write command
   task automatic xfer(input mem_req_t q, input logic sm);
      int n;
      @(posedge clk_sys_in);
      req_valid_in <= 1'b1;
      req_in <= q;
      small_parts_in <= sm;
      n = 0;
      do @(negedge clk_sys_in); while (req_ready_out !== 1'b1 && ++n < 100);
      check(n == 100, 1'b0);
      @(posedge clk_sys_in);
      req_valid_in <= 1'b0;
      n = 0;
      do @(negedge clk_sys_in); while (row_strobe_n_out !== 2'b00 && ++n < 100);
      check(n == 100, 1'b0);
      check({col_strobe_n_out, mem_write_enable_n_out, chip_select_n_out, req_ready_out}, {3'h7, ~q.cs_sel[1:0], 1'b0});
      check(row_col_addr_out, ex_addr(q.row, q.cs_sel));
      check(bank_addr_out, sm ? {~q.cs_sel[3], q.bank[0]} : q.bank);
      n = 0;
      do @(negedge clk_sys_in); while (col_strobe_n_out !== 2'b00 && ++n < 100);
      check(n == 100, 1'b0);
      check({row_strobe_n_out, mem_write_enable_n_out, chip_select_n_out, data_mask_n_out, mem_data_oe_out},
            {2'h3, ~q.write, ~q.cs_sel[1:0], ~q.mask, q.write});
      check(row_col_addr_out, ex_addr(q.col, q.cs_sel));
      if (q.write) begin
         check(mem_data_out, q.wdata);
         shadow[{q.bank[0], q.col[3:0]}] = (shadow[{q.bank[0], q.col[3:0]}] & ~lanes(q.mask)) | (q.wdata & lanes(q.mask));
      end else begin
         n = 0;
         do @(negedge clk_sys_in); while (rd_valid_out !== 1'b1 && ++n < 100);
         check(n == 100, 1'b0);
         check(rd_data_out & lanes(q.mask), shadow[{q.bank[0], q.col[3:0]}] & lanes(q.mask));
      end
   endtask

   initial begin #200000; fails++; finish_test(); end

   initial begin
      fails = 0;
      n_compared = 0;
      foreach (shadow[i]) shadow[i] = '0;
      rst_in = 1'b1;
      small_parts_in = 1'b0;
      req_valid_in = 1'b0;
      req_in = '0;
      r = '0;
      void'($urandom(61));
      repeat (20) @(posedge clk_sys_in);
      // idle levels held during reset
      check({row_strobe_n_out, col_strobe_n_out, chip_select_n_out, mem_write_enable_n_out, data_mask_n_out,
             mem_data_oe_out, rd_valid_out}, {15'h7fff, 2'h0});
      rst_in <= 1'b0;
      // outgoing memory clock must be running straight after reset
      @(negedge clk_sys_in);
      prev = mem_clk_out;
      k = 0;
      repeat (8) begin @(negedge clk_sys_in); k += (mem_clk_out !== prev); prev = mem_clk_out; end
      check(k, 4);
      // write then read back the same place; first pairs are fixed corner masks
      for (int t = 0; t < 40; t++) begin
         if (t % 2 == 0) begin
            r.row = 13'($urandom);
            r.col = 13'($urandom);
            r.bank = 2'($urandom);
            r.cs_sel = {3'($urandom), 1'b1};
            r.wdata = {$urandom, $urandom};
         end
         r.write = (t % 2 == 0);
         r.mask = (t < 4) ? ((t == 2) ? 8'h00 : 8'hff) : 8'($urandom);
         xfer(r, t >= 20);
      end
      finish_test();
   end
endmodule // tb
